// ===== message_send_scoreboard.sv
// Staging register file, send issue, in-flight scoreboards and message transmit
`timescale 1ns/1ps
`default_nettype none
module message_send_scoreboard (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [msg_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [msg_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [msg_pkg::TID_W-1:0] wr_thread,
	input wire logic [msg_pkg::SREG_W-1:0] wr_reg,
	input wire logic [msg_pkg::WORDS-1:0] wr_word_en,
	input wire logic [msg_pkg::DATA_W-1:0] wr_data,
	input wire logic snd_valid,
	output logic snd_ready,
	input wire msg_pkg::desc_t snd_desc,
	input wire logic snd_copy,
	input wire logic [msg_pkg::DATA_W-1:0] snd_copy_data,
	input wire logic wb_valid,
	input wire logic [msg_pkg::TID_W-1:0] wb_thread,
	input wire logic [msg_pkg::GREG_W-1:0] wb_reg,
	input wire logic op_valid,
	input wire logic [msg_pkg::TID_W-1:0] op_thread,
	input wire logic [msg_pkg::GREG_W-1:0] op_reg,
	output logic op_blocked,
	output logic [msg_pkg::THREADS-1:0] thread_suspend,
	output logic msg_valid,
	input wire logic msg_ready,
	output logic [msg_pkg::DATA_W-1:0] msg_data,
	output logic msg_first,
	output logic msg_last,
	output msg_pkg::desc_t msg_desc,
	output logic [msg_pkg::EUN_W-1:0] msg_eu
);
	function automatic logic [msg_pkg::SREGS-1:0] run_mask(input logic [3:0] first, input logic [3:0] len);
		logic [msg_pkg::SREGS-1:0] m;
		m = '0;
		for (int i = 0; i < msg_pkg::SREGS; i++) begin
			// Register numbers wrap mod 16; software must not count on it
			if (i < int'(len)) m[4'(first + 4'(i))] = 1'h1;
		end
		return m;
	endfunction : run_mask

	function automatic logic [msg_pkg::GREGS-1:0] grun(input logic [6:0] first, input logic [4:0] len);
		logic [msg_pkg::GREGS-1:0] m;
		m = '0;
		for (int i = 0; i < msg_pkg::RESP_MAX; i++) begin
			if (i < int'(len)) m[7'(first + 7'(i))] = 1'h1;
		end
		return m;
	endfunction : grun

	msgq_if q ();

	msg_queue u_queue (
		.aclk(aclk),
		.aresetn(aresetn),
		.q(q)
	);

	logic [msg_pkg::DATA_W-1:0] stage_ff [msg_pkg::THREADS][msg_pkg::SREGS];
	logic [msg_pkg::SREGS-1:0] sflag_ff [msg_pkg::THREADS];
	logic [msg_pkg::SREGS-1:0] nxt_sflag [msg_pkg::THREADS];
	logic [msg_pkg::GREGS-1:0] gflag_ff [msg_pkg::THREADS];
	logic [msg_pkg::GREGS-1:0] nxt_gflag [msg_pkg::THREADS];

	// Pending staging write and pending send
	logic wp_ff;
	logic [msg_pkg::TID_W-1:0] wp_thr_ff;
	logic [msg_pkg::SREG_W-1:0] wp_reg_ff;
	logic [msg_pkg::WORDS-1:0] wp_en_ff;
	logic [msg_pkg::DATA_W-1:0] wp_data_ff;
	logic wr_ready_ff;
	logic sp_ff;
	msg_pkg::desc_t sp_desc_ff;
	logic sp_copy_ff;
	logic [msg_pkg::DATA_W-1:0] sp_data_ff;
	logic snd_ready_ff;

	wire wr_take = wr_valid & wr_ready_ff;
	wire wp_hit = sflag_ff[wp_thr_ff][wp_reg_ff];
	wire wp_commit = wp_ff & ~wp_hit;
	wire nxt_wp = wr_take | (wp_ff & ~wp_commit);
	wire snd_take = snd_valid & snd_ready_ff;
	wire [msg_pkg::SREGS-1:0] sp_mask = run_mask(sp_desc_ff.first, sp_desc_ff.len);
	wire sp_overlap = |(sp_mask & sflag_ff[sp_desc_ff.thread]);
	// Waiting for an empty write slot orders every earlier write before the send
	wire sp_issue = sp_ff & ~wp_ff & ~sp_overlap & q.push_ready;
	wire nxt_sp = snd_take | (sp_ff & ~sp_issue);
	wire sp_want_resp = (sp_desc_ff.resp_len != '0) & ~sp_desc_ff.wb_null;
	wire [msg_pkg::GREGS-1:0] sp_gmask = grun(sp_desc_ff.wb_dest, sp_desc_ff.resp_len);

	assign q.push_valid = sp_issue;
	assign q.push_desc = sp_desc_ff;

	// One staging write port: retried write or implicit copy, never both
	wire stg_we = wp_commit | (sp_issue & sp_copy_ff);
	wire [msg_pkg::TID_W-1:0] stg_thr = wp_commit ? wp_thr_ff : sp_desc_ff.thread;
	wire [msg_pkg::SREG_W-1:0] stg_reg = wp_commit ? wp_reg_ff : sp_desc_ff.first;
	wire [msg_pkg::WORDS-1:0] stg_words = wp_commit ? wp_en_ff : '1;
	wire [msg_pkg::DATA_W-1:0] stg_data = wp_commit ? wp_data_ff : sp_data_ff;

	// Transmit side
	msg_pkg::tx_state_t state_ff;
	msg_pkg::tx_state_t nxt_state;
	msg_pkg::desc_t tdesc_ff;
	logic [msg_pkg::SREG_W-1:0] beat_ff;
	logic [msg_pkg::SREG_W-1:0] nxt_beat;
	logic msg_valid_ff;
	logic nxt_msg_valid;
	logic msg_first_ff;
	logic nxt_msg_first;
	logic msg_last_ff;
	logic nxt_msg_last;
	logic [msg_pkg::DATA_W-1:0] msg_data_ff;
	logic [msg_pkg::DATA_W-1:0] nxt_msg_data;
	logic ctrl_en_ff;
	logic [msg_pkg::EUN_W-1:0] eunum_ff;
	logic [msg_pkg::EUN_W-1:0] msg_eu_ff;

	assign q.pop_ready = (state_ff == msg_pkg::TX_IDLE) & ctrl_en_ff;
	wire pop_take = q.pop_valid & q.pop_ready;
	wire msg_take = msg_valid_ff & msg_ready;
	wire tx_clear = (state_ff == msg_pkg::TX_SEND) & msg_take & msg_last_ff;
	wire [msg_pkg::SREGS-1:0] tx_mask = run_mask(tdesc_ff.first, tdesc_ff.len);
	wire [msg_pkg::SREG_W-1:0] beat_inc = beat_ff + 4'h1;
	wire [msg_pkg::SREG_W-1:0] beat_reg = tdesc_ff.first + beat_ff;
	wire [msg_pkg::SREG_W-1:0] next_reg = tdesc_ff.first + beat_inc;

	always_comb begin
		nxt_state = state_ff;
		nxt_beat = beat_ff;
		nxt_msg_valid = msg_valid_ff;
		nxt_msg_first = msg_first_ff;
		nxt_msg_last = msg_last_ff;
		nxt_msg_data = msg_data_ff;
		case (state_ff)
			msg_pkg::TX_IDLE: begin
				if (pop_take) begin
					nxt_beat = '0;
					nxt_state = msg_pkg::TX_LOAD;
				end
			end
			msg_pkg::TX_LOAD: begin
				// Header register, if any, goes out first
				nxt_msg_data = stage_ff[tdesc_ff.thread][beat_reg];
				nxt_msg_valid = 1'h1;
				nxt_msg_first = 1'h1;
				nxt_msg_last = (tdesc_ff.len == 4'h1);
				nxt_state = msg_pkg::TX_SEND;
			end
			msg_pkg::TX_SEND: begin
				if (msg_take) begin
					if (msg_last_ff) begin
						nxt_msg_valid = 1'h0;
						nxt_msg_first = 1'h0;
						nxt_msg_last = 1'h0;
						nxt_state = msg_pkg::TX_IDLE;
					end else begin
						nxt_beat = beat_inc;
						nxt_msg_data = stage_ff[tdesc_ff.thread][next_reg];
						nxt_msg_first = 1'h0;
						nxt_msg_last = (4'(beat_ff + 4'h2) == tdesc_ff.len);
					end
				end
			end
			default: begin
				nxt_state = msg_pkg::TX_IDLE;
			end
		endcase
	end

	// Scoreboards: a set in the same cycle as a clear wins
	always_comb begin
		for (int t = 0; t < msg_pkg::THREADS; t++) begin
			nxt_sflag[t] = sflag_ff[t];
			nxt_gflag[t] = gflag_ff[t];
			if (tx_clear && int'(tdesc_ff.thread) == t) nxt_sflag[t] = nxt_sflag[t] & ~tx_mask;
			if (sp_issue && int'(sp_desc_ff.thread) == t) nxt_sflag[t] = nxt_sflag[t] | sp_mask;
			if (wb_valid && int'(wb_thread) == t) nxt_gflag[t][wb_reg] = 1'h0;
			if (sp_issue && sp_want_resp && int'(sp_desc_ff.thread) == t) begin
				nxt_gflag[t] = nxt_gflag[t] | sp_gmask;
			end
		end
	end

	logic [msg_pkg::THREADS-1:0] nxt_susp;
	always_comb begin
		for (int t = 0; t < msg_pkg::THREADS; t++) begin
			nxt_susp[t] = (wp_ff & wp_hit & (int'(wp_thr_ff) == t))
				| (op_valid & (int'(op_thread) == t) & gflag_ff[t][op_reg]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int t = 0; t < msg_pkg::THREADS; t++) begin
				sflag_ff[t] <= '0;
				gflag_ff[t] <= '0;
			end
			thread_suspend <= '0;
			op_blocked <= 1'h0;
		end else begin
			sflag_ff <= nxt_sflag;
			gflag_ff <= nxt_gflag;
			thread_suspend <= nxt_susp;
			op_blocked <= op_valid & gflag_ff[op_thread][op_reg];
		end
	end

	// Staging storage: written only from the thread, never written by transmit, which reads it
	always_ff @(posedge aclk) begin
		for (int w = 0; w < msg_pkg::WORDS; w++) begin
			if (stg_we && stg_words[w]) begin
				stage_ff[stg_thr][stg_reg][w*msg_pkg::WORD_BITS +: msg_pkg::WORD_BITS] <=
					stg_data[w*msg_pkg::WORD_BITS +: msg_pkg::WORD_BITS];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_ff <= 1'h0;
			wr_ready_ff <= 1'h0;
			sp_ff <= 1'h0;
			snd_ready_ff <= 1'h0;
		end else begin
			wp_ff <= nxt_wp;
			wr_ready_ff <= ~nxt_wp;
			sp_ff <= nxt_sp;
			snd_ready_ff <= ~nxt_sp;
		end
	end

	// Held write is kept unchanged until it commits
	always_ff @(posedge aclk) begin
		if (wr_take) begin
			wp_thr_ff <= wr_thread;
			wp_reg_ff <= wr_reg;
			wp_en_ff <= wr_word_en;
			wp_data_ff <= wr_data;
		end
		if (snd_take) begin
			sp_desc_ff <= snd_desc;
			sp_copy_ff <= snd_copy;
			sp_data_ff <= snd_copy_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= msg_pkg::TX_IDLE;
			beat_ff <= '0;
			msg_valid_ff <= 1'h0;
			msg_first_ff <= 1'h0;
			msg_last_ff <= 1'h0;
			msg_data_ff <= '0;
			tdesc_ff <= '0;
			msg_eu_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			beat_ff <= nxt_beat;
			msg_valid_ff <= nxt_msg_valid;
			msg_first_ff <= nxt_msg_first;
			msg_last_ff <= nxt_msg_last;
			msg_data_ff <= nxt_msg_data;
			if (pop_take) begin
				tdesc_ff <= q.pop_desc;
				msg_eu_ff <= eunum_ff;
			end
		end
	end

	assign wr_ready = wr_ready_ff;
	assign snd_ready = snd_ready_ff;
	assign msg_valid = msg_valid_ff;
	assign msg_first = msg_first_ff;
	assign msg_last = msg_last_ff;
	assign msg_data = msg_data_ff;
	assign msg_desc = tdesc_ff;
	assign msg_eu = msg_eu_ff;

	// AXI4-Lite slave: address and data taken in either order
	logic aw_held_ff;
	logic w_held_ff;
	logic [msg_pkg::ADDR_W-1:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	wire aw_take = s_axi_awvalid & awready_ff;
	wire w_take = s_axi_wvalid & wready_ff;
	wire do_wr = aw_held_ff & w_held_ff & ~bvalid_ff;
	wire nxt_aw_held = (aw_held_ff | aw_take) & ~do_wr;
	wire nxt_w_held = (w_held_ff | w_take) & ~do_wr;
	wire nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);
	wire wa_ctrl = (aw_addr_ff == msg_pkg::OFS_CTRL);
	wire wa_eunum = (aw_addr_ff == msg_pkg::OFS_EUNUM);
	wire wa_ro = (aw_addr_ff == msg_pkg::OFS_SFLAG) | (aw_addr_ff == msg_pkg::OFS_STAT);
	wire wa_hit = wa_ctrl | wa_eunum | wa_ro;
	wire ar_take = s_axi_arvalid & arready_ff;
	wire nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
	wire [31:0] stat_word = {15'h0, (state_ff != msg_pkg::TX_IDLE), 6'h0, thread_suspend, 5'h0, q.count};
	logic [31:0] rd_word;
	logic rd_hit;

	always_comb begin
		rd_hit = 1'h1;
		if (s_axi_araddr == msg_pkg::OFS_CTRL) rd_word = {31'h0, ctrl_en_ff};
		else if (s_axi_araddr == msg_pkg::OFS_EUNUM) rd_word = {24'h0, eunum_ff};
		else if (s_axi_araddr == msg_pkg::OFS_SFLAG) rd_word = {sflag_ff[1], sflag_ff[0]};
		else if (s_axi_araddr == msg_pkg::OFS_STAT) rd_word = stat_word;
		else begin
			rd_word = '0;
			rd_hit = 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'h0;
			w_held_ff <= 1'h0;
			awready_ff <= 1'h0;
			wready_ff <= 1'h0;
			bvalid_ff <= 1'h0;
			bresp_ff <= msg_pkg::RESP_OKAY;
			arready_ff <= 1'h0;
			rvalid_ff <= 1'h0;
			rdata_ff <= '0;
			rresp_ff <= msg_pkg::RESP_OKAY;
			ctrl_en_ff <= msg_pkg::CTRL_EN_RESET;
			eunum_ff <= msg_pkg::EUNUM_RESET;
		end else begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			awready_ff <= ~nxt_aw_held;
			wready_ff <= ~nxt_w_held;
			bvalid_ff <= nxt_bvalid;
			arready_ff <= ~nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (do_wr) bresp_ff <= wa_hit ? msg_pkg::RESP_OKAY : msg_pkg::RESP_SLVERR;
			if (do_wr && wa_ctrl && w_strb_ff[0]) ctrl_en_ff <= w_data_ff[msg_pkg::CTRL_EN_BIT];
			if (do_wr && wa_eunum && w_strb_ff[0]) eunum_ff <= w_data_ff[msg_pkg::EUN_W-1:0];
			if (ar_take) begin
				rdata_ff <= rd_word;
				rresp_ff <= rd_hit ? msg_pkg::RESP_OKAY : msg_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (aw_take) aw_addr_ff <= s_axi_awaddr;
		if (w_take) begin
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule : message_send_scoreboard
`default_nettype wire

// ===== msg_pkg.sv
// Shared constants and types for the message send scoreboard
package msg_pkg;
	localparam int THREADS = 2;
	localparam int TID_W = 1;
	localparam int SREGS = 16;
	localparam int SREG_W = 4;
	localparam int DATA_W = 256;
	localparam int WORDS = 16;
	localparam int WORD_BITS = 16;
	localparam int GREGS = 128;
	localparam int GREG_W = 7;
	localparam int RESP_W = 5;
	localparam int RESP_MAX = 31;
	localparam int TGT_W = 4;
	localparam int MASK_W = 16;
	localparam int EUN_W = 8;
	localparam int QDEPTH = 4;
	localparam int QPTR_W = 2;
	localparam int QCNT_W = 3;
	localparam logic [QCNT_W-1:0] QDEPTH_CNT = 3'h4;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_EUNUM = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SFLAG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0c;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RESET = 1'h1;
	localparam logic [EUN_W-1:0] EUNUM_RESET = 8'h00;
	localparam int STAT_SUSP_POS = 8;
	localparam int STAT_BUSY_POS = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [TID_W-1:0] thread;
		logic [SREG_W-1:0] first;
		logic [SREG_W-1:0] len;
		logic [TGT_W-1:0] target;
		logic [RESP_W-1:0] resp_len;
		logic [GREG_W-1:0] wb_dest;
		logic wb_null;
		logic [MASK_W-1:0] mask;
	} desc_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h1,
		TX_LOAD = 3'h2,
		TX_SEND = 3'h4
	} tx_state_t;
endpackage : msg_pkg

// ===== msgq_if.sv
// Descriptor queue handshake between issue logic and the queue
`timescale 1ns/1ps
`default_nettype none
interface msgq_if;
	logic push_valid;
	logic push_ready;
	msg_pkg::desc_t push_desc;
	logic pop_valid;
	logic pop_ready;
	msg_pkg::desc_t pop_desc;
	logic [msg_pkg::QCNT_W-1:0] count;
	modport producer(output push_valid, push_desc, pop_ready, input push_ready, pop_valid, pop_desc, count);
	modport queue(input push_valid, push_desc, pop_ready, output push_ready, pop_valid, pop_desc, count);
endinterface : msgq_if
`default_nettype wire

// ===== msg_queue.sv
// In-order queue of issued message descriptors
`timescale 1ns/1ps
`default_nettype none
module msg_queue (
	input wire logic aclk,
	input wire logic aresetn,
	msgq_if.queue q
);
	msg_pkg::desc_t mem_ff [msg_pkg::QDEPTH];
	logic [msg_pkg::QPTR_W-1:0] wptr_ff;
	logic [msg_pkg::QPTR_W-1:0] rptr_ff;
	logic [msg_pkg::QCNT_W-1:0] cnt_ff;
	wire push = q.push_valid & q.push_ready;
	wire pop = q.pop_valid & q.pop_ready;

	assign q.push_ready = (cnt_ff != msg_pkg::QDEPTH_CNT);
	assign q.pop_valid = (cnt_ff != '0);
	assign q.pop_desc = mem_ff[rptr_ff];
	assign q.count = cnt_ff;

	// Single queue for all targets keeps per-target issue order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) wptr_ff <= wptr_ff + 2'h1;
			if (pop) rptr_ff <= rptr_ff + 2'h1;
			if (push && !pop) cnt_ff <= cnt_ff + 3'h1;
			else if (pop && !push) cnt_ff <= cnt_ff - 3'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (push) mem_ff[wptr_ff] <= q.push_desc;
	end
endmodule : msg_queue
`default_nettype wire

// ===== msg_sink.sv
// Shared function model: takes message beats and returns writebacks
`timescale 1ns/1ps
`default_nettype none
module msg_sink (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic msg_valid,
	output logic msg_ready,
	input wire logic [msg_pkg::DATA_W-1:0] msg_data,
	input wire logic msg_first,
	input wire logic msg_last,
	input wire msg_pkg::desc_t msg_desc,
	input wire logic [msg_pkg::EUN_W-1:0] msg_eu,
	output logic wb_valid,
	output logic [msg_pkg::TID_W-1:0] wb_thread,
	output logic [msg_pkg::GREG_W-1:0] wb_reg
);
	logic [$bits(msg_pkg::desc_t)+265:0] beats[$];
	msg_pkg::desc_t pend[$];
	msg_pkg::desc_t d;
	int seed = 7;
	initial begin
		msg_ready = 1'b0;
		{wb_valid, wb_thread, wb_reg} = '0;
	end
	// Slow mode stalls most cycles to stretch each message
	always @(posedge aclk) begin
		if (msg_valid && msg_ready) begin
			beats.push_back({msg_first, msg_last, msg_eu, msg_desc, msg_data});
			if (msg_last && msg_desc.resp_len != 5'h0 && !msg_desc.wb_null)
				pend.push_back(msg_desc);
		end
		msg_ready <= aresetn && (!slow || $random(seed) % 3 == 0);
	end
	initial forever begin
		@(posedge aclk);
		if (pend.size() != 0) begin
			d = pend.pop_front();
			repeat (20) @(posedge aclk);
			for (int i = 0; i < d.resp_len; i++) begin
				wb_valid <= 1'b1;
				wb_thread <= d.thread;
				wb_reg <= d.wb_dest + 7'(i);
				@(posedge aclk);
			end
			wb_valid <= 1'b0;
			wb_reg <= ~wb_reg;
		end
	end
endmodule : msg_sink
`default_nettype wire

// ===== message_send_scoreboard_checker.sv
// Port-level assertions for the message send scoreboard
`timescale 1ns/1ps
`default_nettype none
module message_send_scoreboard_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic msg_valid,
	input wire logic msg_ready,
	input wire logic [msg_pkg::DATA_W-1:0] msg_data,
	input wire logic msg_first,
	input wire logic msg_last,
	input wire msg_pkg::desc_t msg_desc
);
	logic [3:0] beat_ff;
	logic [3:0] nxt_beat;
	assign nxt_beat = (msg_valid && msg_ready) ? (msg_last ? 4'h0 : beat_ff + 4'h1) : beat_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) beat_ff <= 4'h0;
		else beat_ff <= nxt_beat;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_beat; msg_valid && msg_ready; endsequence
	sequence s_wtake; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	property p_hold; msg_valid && !msg_ready |=> msg_valid && $stable(msg_data) && $stable(msg_desc)
		&& $stable(msg_first) && $stable(msg_last); endproperty
	property p_first; msg_valid |-> msg_first == (beat_ff == 4'h0); endproperty
	property p_last; msg_valid |-> msg_last == (beat_ff == msg_desc.len - 4'h1); endproperty
	property p_len; msg_valid |-> msg_desc.len != 4'h0; endproperty
	property p_end; s_beat ##0 msg_last |=> !msg_valid; endproperty
	property p_wr; wr_valid && wr_ready |=> !wr_ready; endproperty
	property p_aw; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
	property p_b; s_wtake |-> ##[1:4] s_axi_bvalid; endproperty
	property p_r; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
	a_hold: assert property (p_hold) else $error("message beat changed while stalled");
	a_first: assert property (p_first) else $error("first marker misplaced");
	a_last: assert property (p_last) else $error("last marker misplaced");
	a_len: assert property (p_len) else $error("empty payload sent");
	a_end: assert property (p_end) else $error("valid held after last beat");
	a_wr: assert property (p_wr) else $error("write ready held after take");
	a_aw: assert property (p_aw) else $error("address ready held after take");
	a_b: assert property (p_b) else $error("write response late");
	a_r: assert property (p_r) else $error("read response late");
endmodule : message_send_scoreboard_checker
bind message_send_scoreboard message_send_scoreboard_checker i_chk (.*);
`default_nettype wire

// ===== message_send_scoreboard_test.sv
// Self-checking bench for the message send scoreboard
`timescale 1ns/1ps
`default_nettype none
module message_send_scoreboard_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wr_valid, wr_ready, snd_valid, snd_ready;
	logic snd_copy, wb_valid, op_valid, op_blocked, msg_valid, msg_ready, msg_first, msg_last, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr, msg_eu, eu;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, wr_reg;
	logic [1:0] s_axi_bresp, s_axi_rresp, thread_suspend;
	logic [0:0] wr_thread, wb_thread, op_thread;
	logic [15:0] wr_word_en;
	logic [255:0] wr_data, snd_copy_data, msg_data;
	logic [6:0] wb_reg, op_reg;
	msg_pkg::desc_t snd_desc, msg_desc, d;
	logic [255:0] sh [2][16];
	logic [$bits(msg_pkg::desc_t)+265:0] expq[$];
	int err_count, samples_checked, n;
	int seed = 44352;
	message_send_scoreboard i_dut (.*);
	msg_sink i_sink (.*);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic chk(input logic [511:0] got, input logic [511:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic lim(input int k);
		if (k >= 2000) begin
			err_count++;
			$display("CHECK FAILED %0t wait timed out", $time);
			end_of_test;
		end
	endtask : lim
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 2000; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		lim(n);
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 2000; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		lim(n);
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask : rchk
	task automatic stg_wr(input logic t, input logic [3:0] r, input logic [15:0] we, input logic [255:0] v);
		@(posedge aclk);
		{wr_thread, wr_reg, wr_word_en, wr_data, wr_valid} <= {t, r, we, v, 1'b1};
		for (n = 0; n < 2000; n++) begin
			@(posedge aclk);
			if (wr_ready) break;
		end
		lim(n);
		wr_valid <= 1'b0;
		for (int w = 0; w < 16; w++)
			if (we[w]) sh[t][r][16*w +: 16] = v[16*w +: 16];
	endtask : stg_wr
	function automatic logic [$bits(msg_pkg::desc_t)+265:0] bt(msg_pkg::desc_t s, int i);
		return {1'(i == 0), 1'(i == s.len - 1), eu, s, sh[s.thread][s.first + 4'(i)]};
	endfunction : bt
	function automatic msg_pkg::desc_t mk(logic t, logic [3:0] f, logic [3:0] l, logic [3:0] tg, logic [4:0] rl,
		logic [6:0] wd);
		return {t, f, l, tg, rl, wd, 1'(rl == 5'h0), 16'($random(seed))};
	endfunction : mk
	task automatic send(input msg_pkg::desc_t s, input logic c, input logic [255:0] cv);
		@(posedge aclk);
		{snd_desc, snd_copy, snd_copy_data, snd_valid} <= {s, c, cv, 1'b1};
		for (n = 0; n < 2000; n++) begin
			@(posedge aclk);
			if (snd_ready) break;
		end
		lim(n);
		snd_valid <= 1'b0;
		if (c) sh[s.thread][s.first] = cv;
		for (int i = 0; i < s.len; i++)
			expq.push_back(bt(s, i));
	endtask : send
	task automatic drain;
		for (n = 0; n < 2000 && i_sink.beats.size() < expq.size(); n++)
			@(posedge aclk);
		lim(n);
		while (expq.size() != 0)
			chk(i_sink.beats.pop_front(), expq.pop_front());
	endtask : drain
	task automatic opq(input logic t, input logic [6:0] r, input logic e);
		@(posedge aclk);
		{op_valid, op_thread, op_reg} <= {1'b1, t, r};
		@(posedge aclk);
		op_valid <= 1'b0;
		@(posedge aclk);
		chk(op_blocked, e);
	endtask : opq
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
		{s_axi_rready, wr_valid, wr_thread, wr_reg, wr_word_en, wr_data, snd_valid, snd_desc, snd_copy} = '0;
		{snd_copy_data, op_valid, op_thread, op_reg, slow, err_count, samples_checked} = '0;
		s_axi_wstrb = 4'hf;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(msg_pkg::OFS_CTRL, {31'h0, msg_pkg::CTRL_EN_RESET}, msg_pkg::RESP_OKAY);
		rchk(msg_pkg::OFS_EUNUM, {24'h0, msg_pkg::EUNUM_RESET}, msg_pkg::RESP_OKAY);
		axi_wr(msg_pkg::OFS_SFLAG, 32'hffffffff, msg_pkg::RESP_OKAY);
		rchk(msg_pkg::OFS_SFLAG, 32'h0, msg_pkg::RESP_OKAY);
		rchk(8'h10, 32'h0, msg_pkg::RESP_SLVERR);
		axi_wr(8'h14, 32'h0, msg_pkg::RESP_SLVERR);
		eu = 8'($random(seed));
		axi_wr(msg_pkg::OFS_EUNUM, {24'h0, eu}, msg_pkg::RESP_OKAY);
		rchk(msg_pkg::OFS_EUNUM, {24'h0, eu}, msg_pkg::RESP_OKAY);
		// Low strobe bit clear: the unit number must not move
		s_axi_wstrb <= 4'he;
		axi_wr(msg_pkg::OFS_EUNUM, {24'h0, ~eu}, msg_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rchk(msg_pkg::OFS_EUNUM, {24'h0, eu}, msg_pkg::RESP_OKAY);
		axi_wr(msg_pkg::OFS_CTRL, 32'h0, msg_pkg::RESP_OKAY);
		for (int r = 1; r < 6; r++)
			stg_wr(1'b0, 4'(r), 16'hffff, {8{$random(seed)}});
		send(mk(1'b0, 4'h1, 4'h3, 4'h2, 5'h0, 7'h0), 1'b0, '0);
		send(mk(1'b0, 4'h4, 4'h2, 4'h5, 5'h0, 7'h0), 1'b0, '0);
		rchk(msg_pkg::OFS_SFLAG, 32'h3e, msg_pkg::RESP_OKAY);
		stg_wr(1'b0, 4'h2, 16'h00f0, {8{$random(seed)}});
		for (n = 0; n < 20 && thread_suspend !== 2'h1; n++)
			@(posedge aclk);
		chk(thread_suspend, 2'h1);
		rchk(msg_pkg::OFS_STAT, (32'h1 << msg_pkg::STAT_SUSP_POS) | 32'h2, msg_pkg::RESP_OKAY);
		slow <= 1'b1;
		axi_wr(msg_pkg::OFS_CTRL, 32'h1, msg_pkg::RESP_OKAY);
		drain;
		rchk(msg_pkg::OFS_SFLAG, 32'h0, msg_pkg::RESP_OKAY);
		chk(thread_suspend, 2'h0);
		// Resend with the retried write merged into the old contents
		send(mk(1'b0, 4'h1, 4'h3, 4'h7, 5'h0, 7'h0), 1'b0, '0);
		drain;
		stg_wr(1'b1, 4'h8, 16'hffff, {8{$random(seed)}});
		send(mk(1'b1, 4'h7, 4'h2, 4'h3, 5'h3, 7'h28), 1'b1, {8{$random(seed)}});
		opq(1'b1, 7'h2a, 1'b1);
		opq(1'b1, 7'h2b, 1'b0);
		opq(1'b0, 7'h29, 1'b0);
		drain;
		repeat (40) @(posedge aclk);
		opq(1'b1, 7'h2a, 1'b0);
		slow <= 1'b0;
		for (int k = 0; k < 16; k++) begin
			d = mk(1'($random(seed)), 4'h0, 4'(1 + k % 15), 4'(k), 5'h0, 7'h0);
			d.first = 4'(1 + $unsigned($random(seed)) % (16 - d.len));
			for (int i = 0; i < d.len; i++)
				stg_wr(d.thread, d.first + 4'(i), 16'hffff, {8{$random(seed)}});
			stg_wr(d.thread, d.first, 16'($random(seed)), {8{$random(seed)}});
			send(d, k[0], {8{$random(seed)}});
			if (k[1]) drain;
		end
		drain;
		chk(i_sink.beats.size(), 0);
		end_of_test;
	end
endmodule : message_send_scoreboard_test
`default_nettype wire
